//--- logic/comc_pkg.sv
// Package for the operating-mode control block: register map, fields, modes.
// Assumes a 32-bit APB slave with one aligned word per register.
`default_nettype none
package comc_pkg;
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;       // Operating control register
	localparam logic [7:0] STATUS_OFFSET = 8'h04;       // Mode status register
	localparam logic [7:0] SLEEP_OFFSET  = 8'h08;       // Sleep instruction strobe
	localparam int         TSEL_BIT      = 6;           // timer_clock_select
	localparam int         CSEL_BIT      = 5;           // cpu_clock_select
	localparam int         IDLE_BIT      = 4;           // Halt-mode select
	localparam logic [7:0] CTRL_RESET    = 8'h20;       // Main clock for the CPU, sub clock for the timers
	localparam logic [7:0] CTRL_MASK     = 8'h70;       // Writable bits
	typedef enum logic [1:0] {
		COMC_NORMAL = 2'h0,
		COMC_GREEN  = 2'h1,
		COMC_IDLE   = 2'h3,
		COMC_SLEEP  = 2'h2
	} comc_mode_t;
endpackage : comc_pkg
`default_nettype wire

//--- logic/comc_clk_sel.sv
// Timer clock source selection as a one-cycle tick.
// Assumes both source ticks are enables on sys_clk_i.
`default_nettype none
module comc_clk_sel (
	input  wire logic sel_i,       // 1 selects main tick
	input  wire logic sub_tick_i,  // Sub clock tick
	input  wire logic main_tick_i, // Main clock tick
	output logic      tick_o       // Selected tick
);
	// Plain mux; both inputs already share the system clock
	assign tick_o = sel_i ? main_tick_i : sub_tick_i;
endmodule : comc_clk_sel
`default_nettype wire

//--- logic/comc_top.sv
// Operating-mode control: clock source selects, sleep/idle entry, oscillator gating.
// Assumes an APB master on sys_clk_i and a wake strobe from outside logic.
//
// Our own choices: register access over APB and the address map.
`default_nettype none
// Behaviour
// RQ1: Timer counters tick from sub clock when select is 0, main when 1.
// RQ2: Processor clocks from sub oscillator at select 0, main oscillator at 1.
// RQ3: Clearing CPU clock select stops the main oscillator.
// RQ4: Sleep instruction with halt-mode bit 0 enters full sleep.
// RQ5: Sleep instruction with halt-mode bit 1 enters idle instead.
// RQ6: Full sleep stops both oscillators and halts the processor.
// RQ7: Normal mode runs both oscillators, processor on main oscillator.
// RQ8: Halt-mode bit acts only when the sleep instruction executes.
module comc_top (
	input  wire logic        sys_clk_i,      // 200 MHz system clock
	input  wire logic        rst_i,          // Synchronous reset, active high
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB enable
	input  wire logic        pwrite,         // APB direction
	input  wire logic [7:0]  paddr,          // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic      [31:0] prdata,         // APB read data
	output logic             pready,         // APB ready
	output logic             pslverr,        // APB error
	input  wire logic        sleep_instr_i,  // Sleep instruction executed, pulse
	input  wire logic        wake_i,         // Wake-up event, pulse
	input  wire logic        sub_tick_i,     // Sub clock enable tick
	input  wire logic        main_tick_i,    // Main clock enable tick
	output logic             main_osc_en_o,  // Main oscillator running
	output logic             sub_osc_en_o,   // Sub oscillator running
	output logic             cpu_on_main_o,  // Processor clock from main
	output logic             cpu_run_o,      // Processor executing
	output logic             timer_tick_o,   // Tick for timer_zero/two/three
	output logic [1:0]       mode_o          // Current operating mode
);
	// All block state in one record, registered in one place
	typedef struct packed {
		logic [7:0]          ctrl;
		comc_pkg::comc_mode_t mode;
		logic [31:0]         rdata;
		logic                main_en;
		logic                sub_en;
		logic                cpu_main;
		logic                run;
		logic                src_main;  // Processor source latched at halt entry
	} comc_state_t;

	comc_state_t st;
	comc_state_t next_st;
	logic        acc;
	logic        wr;
	logic        hit;
	logic        sleep_go;
	logic        ctrl_wr;
	logic        sleep_wr;

	// Address match for one register word; all eight address bits must agree
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	// Running mode chosen by the CPU clock select bit
	function automatic comc_pkg::comc_mode_t run_mode(input logic [7:0] ctrl);
		if (ctrl[comc_pkg::CSEL_BIT]) begin
			run_mode = comc_pkg::COMC_NORMAL;
		end else begin
			run_mode = comc_pkg::COMC_GREEN;
		end
	endfunction : run_mode

	// Halt mode chosen by the halt-mode select bit at the sleep instruction
	function automatic comc_pkg::comc_mode_t halt_mode(input logic [7:0] ctrl);
		if (ctrl[comc_pkg::IDLE_BIT]) begin
			halt_mode = comc_pkg::COMC_IDLE;
		end else begin
			halt_mode = comc_pkg::COMC_SLEEP;
		end
	endfunction : halt_mode

	// Only the three control bits are storable; the rest read back as zero
	function automatic logic [7:0] ctrl_write(input logic [31:0] d);
		ctrl_write = d[7:0] & comc_pkg::CTRL_MASK;
	endfunction : ctrl_write

	// Status word layout: run, cpu source, sub, main, then the mode code
	function automatic logic [31:0] status_word(input comc_state_t s);
		status_word = {26'h0, s.run, s.cpu_main, s.sub_en, s.main_en, s.mode};
	endfunction : status_word

	// Read decode; unmapped and write-only words read as zero
	// Status is sampled at setup, so it shows the state before the access
	function automatic logic [31:0] read_word(input logic [7:0] a, input comc_state_t s);
		read_word = 32'h0;
		if (reg_hit(a, comc_pkg::CTRL_OFFSET)) begin
			read_word = {24'h0, s.ctrl};
		end else if (reg_hit(a, comc_pkg::STATUS_OFFSET)) begin
			read_word = status_word(s);
		end
	endfunction : read_word

	// Zero-wait APB: every access completes in its first access cycle
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign ctrl_wr = wr & reg_hit(paddr, comc_pkg::CTRL_OFFSET);
	// Only bit 0 of the strobe word acts; other bits are ignored
	assign sleep_wr = wr & reg_hit(paddr, comc_pkg::SLEEP_OFFSET) & pwdata[0];
	assign hit     = reg_hit(paddr, comc_pkg::CTRL_OFFSET)
		| reg_hit(paddr, comc_pkg::STATUS_OFFSET)
		| reg_hit(paddr, comc_pkg::SLEEP_OFFSET);
	assign pready  = 1'b1;
	// Error flags unmapped words only; writes to the status word are dropped
	assign pslverr = acc & ~hit;
	// Both sleep sources act alike; a strobe during a halt is ignored
	assign sleep_go = sleep_instr_i | sleep_wr;

	// Next-state logic for registers and the mode sequencer
	always_comb begin
		next_st = st;
		if (ctrl_wr) begin
			next_st.ctrl = ctrl_write(pwdata);
		end

		unique case (st.mode)
			comc_pkg::COMC_NORMAL,
			comc_pkg::COMC_GREEN: begin
				// A control write in the same cycle as sleep uses the new bits
				// RQ8: halt bit sampled only here
				if (sleep_go) begin
					// RQ4: idle bit 0 means sleep
					// RQ5: idle bit 1 means idle
					next_st.mode = halt_mode(next_st.ctrl);
					// Later writes while halted must not switch the idle source
					next_st.src_main = next_st.ctrl[comc_pkg::CSEL_BIT];
				end else begin
					next_st.mode = run_mode(next_st.ctrl);
				end
			end
			comc_pkg::COMC_IDLE,
			comc_pkg::COMC_SLEEP: begin
				// Wake returns to the mode chosen by the CPU clock select
				// A wake outside a halt has no effect
				if (wake_i) begin
					next_st.mode = run_mode(next_st.ctrl);
				end
			end
		endcase

		// Oscillator and processor outputs follow the next mode
		// Registered together with the mode, so they never lag it by a cycle
		unique case (next_st.mode)
			comc_pkg::COMC_NORMAL: begin
				// RQ7: both running, processor on main
				next_st.main_en  = 1'b1;
				next_st.sub_en   = 1'b1;
				next_st.cpu_main = 1'b1;
				next_st.run      = 1'b1;
			end
			comc_pkg::COMC_GREEN: begin
				// RQ3: main stopped on sub clock
				// RQ2: processor on sub oscillator
				// Sub clock keeps running so the timers can still count
				next_st.main_en  = 1'b0;
				next_st.sub_en   = 1'b1;
				next_st.cpu_main = 1'b0;
				next_st.run      = 1'b1;
			end
			comc_pkg::COMC_IDLE: begin
				// Idle keeps the source selected before entry, processor halted
				next_st.main_en  = next_st.src_main;
				next_st.sub_en   = 1'b1;
				next_st.cpu_main = next_st.src_main;
				next_st.run      = 1'b0;
			end
			comc_pkg::COMC_SLEEP: begin
				// RQ6: all stopped
				next_st.main_en  = 1'b0;
				next_st.sub_en   = 1'b0;
				next_st.cpu_main = 1'b0;
				next_st.run      = 1'b0;
			end
		endcase

		// Read data registered, so it is valid in the access cycle's setup+1
		next_st.rdata = 32'h0;
		if (psel && !penable && !pwrite) begin
			next_st.rdata = read_word(paddr, st);
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st.ctrl     <= comc_pkg::CTRL_RESET;
			st.mode     <= comc_pkg::COMC_NORMAL;
			st.rdata    <= 32'h0;
			st.main_en  <= 1'b1;
			st.sub_en   <= 1'b1;
			st.cpu_main <= 1'b1;
			st.run      <= 1'b1;
			st.src_main <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign prdata        = st.rdata;
	assign main_osc_en_o = st.main_en;
	assign sub_osc_en_o  = st.sub_en;
	assign cpu_on_main_o = st.cpu_main;
	assign cpu_run_o     = st.run;
	assign mode_o        = st.mode;

	// Gating by the enables keeps a stopped oscillator from ticking the timers
	// RQ1: timer source select
	comc_clk_sel u_tsel (
		.sel_i       (st.ctrl[comc_pkg::TSEL_BIT]),
		.sub_tick_i  (sub_tick_i & st.sub_en),
		.main_tick_i (main_tick_i & st.main_en),
		.tick_o      (timer_tick_o)
	);
endmodule : comc_top
`default_nettype wire

//--- tb/comc_top_properties.sv
// Checker for the operating-mode outputs of comc_top.
// Assumes it sees the top ports only; it is bound in below.
`default_nettype none
module comc_props (
	input wire logic       sys_clk_i, rst_i, psel, penable, pwrite, sleep_instr_i, wake_i,
	input wire logic       sub_tick_i, main_tick_i, main_osc_en_o, sub_osc_en_o,
	input wire logic       cpu_on_main_o, cpu_run_o, timer_tick_o,
	input wire logic [7:0] paddr,
	input wire logic [1:0] mode_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Any write to the strobe word may act as a sleep, so it is excluded
	wire logic slp = sleep_instr_i || (psel && penable && pwrite && paddr == 8'h08);
	a_normal_osc: assert property (
		mode_o == 2'h0 |-> main_osc_en_o && sub_osc_en_o && cpu_on_main_o) else $error("normal bad");
	a_green_main_off: assert property (
		mode_o == 2'h1 |-> !main_osc_en_o && !cpu_on_main_o && sub_osc_en_o) else $error("green bad");
	a_main_src: assert property (
		$rose(cpu_on_main_o) |-> mode_o == 2'h0) else $error("cpu source bad");
	a_sleep_entry: assert property (
		!mode_o[1] && sleep_instr_i |=> mode_o[1] && !cpu_run_o) else $error("no halt entry");
	a_sleep_off: assert property (
		mode_o == 2'h2 |-> !main_osc_en_o && !sub_osc_en_o && !cpu_run_o) else $error("sleep bad");
	a_idle_state: assert property (
		mode_o == 2'h3 |-> !cpu_run_o && sub_osc_en_o) else $error("idle bad");
	a_halt_bit_inert: assert property (
		!mode_o[1] && !slp |=> !mode_o[1]) else $error("halt without sleep");
	a_sleep_hold: assert property (
		mode_o == 2'h2 && !wake_i |=> mode_o == 2'h2) else $error("sleep left");
	a_tick_src: assert property (
		timer_tick_o |-> sub_tick_i && sub_osc_en_o || main_tick_i && main_osc_en_o)
		else $error("tick source bad");
	c_idle: cover property (mode_o == 2'h3);
	c_sleep: cover property (mode_o == 2'h2);
	c_green_back: cover property (mode_o == 2'h1 ##1 mode_o == 2'h0);
endmodule : comc_props
bind comc_top comc_props i_comc_props (.*);
`default_nettype wire

//--- tb/comc_top_tb.sv
// Self-checking bench for comc_top: APB accesses, sleep, idle and wake.
// Assumes one 200 MHz clock and zero-wait APB answers.
`default_nettype none
module comc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic        sleep_instr_i = 0, wake_i = 0, sub_tick_i = 0, main_tick_i = 0;
	logic [7:0]  paddr = 8'h00, ctl;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, main_osc_en_o, sub_osc_en_o, cpu_on_main_o, cpu_run_o;
	logic        timer_tick_o;
	logic [1:0]  mode_o, m;
	int          seed = 47465, tseed = 47465, mismatches = 0, check_count = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	comc_top i_comc_top (.*);
	// Own seed for ticks, so draw order never depends on process order
	always @(posedge sys_clk_i) begin
		{sub_tick_i, main_tick_i} <= 2'($random(tseed));
	end
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One APB transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'h0;
		@(posedge sys_clk_i);
		penable <= 1'h1;
		do @(posedge sys_clk_i); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk_i);
	endtask : apb
	// Status word per mode; idle keeps the source selected at entry
	function logic [31:0] exp_st(input logic [1:0] md, input logic cs);
		case (md)
			2'h0: return 32'h3C;
			2'h1: return 32'h29;
			2'h3: return {26'h0, 1'h0, cs, 1'h1, cs, 2'h3};
			default: return 32'h02;
		endcase
	endfunction : exp_st
	task st(input logic [1:0] md);
		@(posedge sys_clk_i);
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, exp_st(md, ctl[5]));
	endtask : st
	task pulse(input logic s);
		if (s) sleep_instr_i <= 1'h1;
		else wake_i <= 1'h1;
		@(posedge sys_clk_i);
		sleep_instr_i <= 1'h0;
		wake_i <= 1'h0;
	endtask : pulse
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000;
		mismatches++;
		report_and_stop;
	end
	// Reset, then random control words with halt entries and wakes
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		ctl = 8'h20;
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h20);
		st(2'h0);
		apb(1'h0, 8'hF0, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		for (int i = 0; i < 40; i++) begin
			ctl = 8'($random(seed)) & 8'h70;
			if (i < 2) ctl = i[0] ? 8'h10 : 8'h70;
			apb(1'h1, 8'h00, {24'h0, ctl});
			m = {1'h0, ~ctl[5]};
			#1 chk({31'h0, timer_tick_o}, ctl[6] ? main_tick_i & ~m[0] : sub_tick_i);
			st(m);
			if (i[0] || i[1]) begin
				if (i[0]) pulse(1'h1);
				else apb(1'h1, 8'h08, 32'h1);
				st(ctl[4] ? 2'h3 : 2'h2);
				pulse(1'h0);
				st(m);
			end
			$display("iteration %0d done", i);
		end
		report_and_stop;
	end
endmodule : comc_top_tb
`default_nettype wire
